// ===== design/pmc_capability_regs.sv
/*
  pmc_capability_regs: read-only capability bank of a performance
  monitor: global capability, one event support word per category
  and optional per-counter capability registers, plus the event
  filter applied to counter configuration writes.
  Assumes a simple single-cycle request port from the host register
  interface on the same clock, 64-bit aligned accesses.
*/
// Operation
// - one category event support register per category the global count reports
// - category register sits at base plus 0x80 plus category times 8
// - bits 27:0 are event support mask, bits 63:28 reserved
// - unsupported event bits in a configuration write are dropped
// - category with no supported event reads zero mask
// - per-counter registers exist only when global flag reads one
// - one per-counter register per counter, overriding global values
// - per-counter register sits at base plus 0x800 plus counter times 64
// - bits 7:0 give counter width, bits 27:8 unused
// - bits 31:28 give number of category and events pairs
// - zero pairs lets the counter use every global category
// - entry k has category at 32+32k and events four bits above
// - global register bits 19:16 hold number of event categories
// - global register bit 52 flags per-counter registers present
`timescale 1ns/10ps
`default_nettype none

module pmc_capability_regs #(
  parameter logic [15:0]  TABLE_BASE  = 16'h0000,
  parameter int           NUM_CATS    = 5,
  parameter int           NUM_CNTRS   = 4,
  parameter bit           PER_CNTR_EN = 1'b1,
  parameter logic [7:0]   CNTR_WIDTH  = 8'h30,
  parameter logic [7:0]   FILTERS     = 8'h00,
  parameter logic [15:0]  GLOBAL_CATS = 16'h001f,
  // event support mask per category, category c at [28c +: 28]
  parameter logic [16*28-1:0] EVT_MASKS = {16{28'h000000f}},
  // per-counter width, counter n at [8n +: 8]
  parameter logic [64*8-1:0]  CNTR_WIDTHS = {64{8'h20}},
  // per-counter entry count, counter n at [4n +: 4]
  parameter logic [64*4-1:0]  CNTR_NENT = '0,
  // entries, counter n entry k at [32*(15n+k) +: 32]
  parameter logic [64*15*32-1:0] CNTR_ENTRIES = '0
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        rd_req,
  input  wire logic        wr_req,
  input  wire logic [15:0] addr,
  output logic             rd_valid,
  output logic      [63:0] rd_data,
  output logic             wr_done,
  input  wire logic        cfg_wr,
  input  wire logic [5:0]  cfg_counter,
  input  wire logic [3:0]  cfg_category,
  input  wire logic [27:0] cfg_events,
  output logic             cfg_valid,
  output logic      [27:0] cfg_events_kept
);

  // the counter table keeps at least one word even with no counter
  // reported, so the memory never collapses to zero depth
  localparam int ROM_DEPTH = (NUM_CNTRS > 0) ? NUM_CNTRS * 8 : 1;
  // nine index bits cover 64 counters of eight words each
  localparam int ROM_AW    = 9;

  // ----------------------------------------------------------------
  // constant register images
  // ----------------------------------------------------------------
  // global capability word; fields not modelled stay zero
  function automatic logic [63:0] build_gcap();
    logic [63:0] w;
    w = '0;
    w[pmc_pkg::GCAP_NCNT_LSB +: 6] = 6'(NUM_CNTRS);
    w[pmc_pkg::GCAP_CWID_LSB +: 8] = CNTR_WIDTH;
    w[pmc_pkg::GCAP_NCAT_LSB +: 4] = 4'(NUM_CATS);
    w[pmc_pkg::GCAP_GCAT_LSB +: 16] = GLOBAL_CATS;
    w[pmc_pkg::GCAP_FILT_LSB +: 8] = FILTERS;
    w[pmc_pkg::GCAP_PCC_BIT] = PER_CNTR_EN;
    return w;
  endfunction

  // flat table of all per-counter registers, eight words each
  function automatic logic [ROM_DEPTH*64-1:0] build_ccap();
    logic [ROM_DEPTH*64-1:0] t;
    logic [511:0]            r;
    logic [3:0]              n;
    t = '0;
    for (int c = 0; c < NUM_CNTRS; c++) begin
      r = '0;
      n = CNTR_NENT[c*4 +: 4];
      r[pmc_pkg::CCAP_CWID_LSB +: 8] = CNTR_WIDTHS[c*8 +: 8];
      r[pmc_pkg::CCAP_NENT_LSB +: 4] = n;
      // only the reported pairs are filled; the rest read zero
      for (int k = 0; k < pmc_pkg::MAX_ENT; k++) begin
        if (k < 32'(n)) begin
          r[pmc_pkg::CCAP_ENT0_LSB + k*pmc_pkg::ENT_W +: 32] =
            CNTR_ENTRIES[(c*pmc_pkg::MAX_ENT + k)*32 +: 32];
        end
      end
      t[c*512 +: 512] = r;
    end
    return t;
  endfunction

  localparam logic [63:0]            GCAP_WORD = build_gcap();
  localparam logic [ROM_DEPTH*64-1:0] CCAP_TAB = build_ccap();

  // ----------------------------------------------------------------
  // event filter for counter configuration writes
  // ----------------------------------------------------------------
  // per-counter entries, when present, replace the global category flags and narrow the category mask
  function automatic logic [27:0] allowed_events(
    input logic [5:0] cntr,
    input logic [3:0] cat
  );
    logic [27:0] mask;
    logic [27:0] per;
    logic [3:0]  n;
    logic [31:0] ent;
    mask = '0;
    per  = '0;
    n    = '0;
    ent  = '0;
    if (32'(cat) < NUM_CATS) begin
      mask = EVT_MASKS[cat*28 +: 28];
    end
    // a counter past the reported count keeps nothing, so a stray
    // configuration write cannot enable events on a missing counter
    if (32'(cntr) >= NUM_CNTRS) begin
      mask = '0;
    end else if (PER_CNTR_EN) begin
      n = CNTR_NENT[cntr*4 +: 4];
      if (n == 4'h0) begin
        if (!GLOBAL_CATS[cat]) begin
          mask = '0;
        end
      end else begin
        for (int k = 0; k < pmc_pkg::MAX_ENT; k++) begin
          ent = CNTR_ENTRIES[(32'(cntr)*pmc_pkg::MAX_ENT + k)*32 +: 32];
          if (k < 32'(n) &&
              ent[pmc_pkg::ENT_CAT_LSB +: 4] == cat) begin
            per = per | ent[pmc_pkg::ENT_EVT_LSB +: 28];
          end
        end
        mask = mask & per;
      end
    end else if (!GLOBAL_CATS[cat]) begin
      mask = '0;
    end
    return mask;
  endfunction

  // unsupported bits are dropped before they reach configuration;
  // the result is zero while the strobe is low so idle output is clean
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_valid       <= 1'b0;
      cfg_events_kept <= '0;
    end else begin
      cfg_valid       <= cfg_wr;
      cfg_events_kept <= cfg_wr ?
        (cfg_events & allowed_events(cfg_counter, cfg_category)) :
        '0;
    end
  end

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  logic [15:0] offs;
  logic [15:0] evt_rel;
  logic [15:0] ccap_rel;
  logic        aligned;
  logic        hit_gcap;
  logic        hit_evt;
  logic        hit_ccap;
  logic [1:0]  next_src;

  // all decoding works on offsets from the table base, so the bank
  // can sit anywhere in the host's register window
  assign offs     = 16'(addr - TABLE_BASE);
  assign evt_rel  = 16'(offs - pmc_pkg::EVT_OFS);
  assign ccap_rel = 16'(offs - pmc_pkg::CCAP_OFS);
  assign aligned  = (offs[2:0] == 3'h0);
  assign hit_gcap = aligned && (offs == pmc_pkg::GCAP_OFS);
  // one word per reported category, stride 8 bytes
  assign hit_evt  = aligned && (offs >= pmc_pkg::EVT_OFS) &&
                    (32'(evt_rel) <
                     NUM_CATS * pmc_pkg::EVT_STRIDE);
  // counter region decodes only when the flag is set
  assign hit_ccap = PER_CNTR_EN && aligned &&
                    (offs >= pmc_pkg::CCAP_OFS) &&
                    (32'(ccap_rel) <
                     NUM_CNTRS * pmc_pkg::CCAP_STRIDE);

  // source select; an unmapped address answers zero
  always_comb begin
    next_src = pmc_pkg::SRC_NONE;
    if (hit_gcap) begin
      next_src = pmc_pkg::SRC_GCAP;
    end else if (hit_evt) begin
      next_src = pmc_pkg::SRC_EVT;
    end else if (hit_ccap) begin
      next_src = pmc_pkg::SRC_CCAP;
    end
  end

  // ----------------------------------------------------------------
  // read pipeline, stage one
  // ----------------------------------------------------------------
  logic        s1_valid;
  logic [1:0]  s1_src;
  logic [63:0] s1_word;
  logic [63:0] rom_data;
  logic [3:0]  evt_idx;
  logic [27:0] cat_mask [pmc_pkg::MAX_CATS];

  assign evt_idx = evt_rel[6:3];

  // one support image per category slot; slots past the reported
  // count are tied to zero so a wide parameter cannot leak through
  for (genvar g = 0; g < pmc_pkg::MAX_CATS; g++) begin : g_cat
    if (g < NUM_CATS) begin : g_used
      assign cat_mask[g] = EVT_MASKS[g*28 +: 28];
    end else begin : g_unused
      assign cat_mask[g] = '0;
    end
  end

  // request bookkeeping travels one stage behind the request
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_valid <= 1'b0;
      s1_src   <= pmc_pkg::SRC_NONE;
    end else begin
      s1_valid <= rd_req;
      s1_src   <= rd_req ? next_src : pmc_pkg::SRC_NONE;
    end
  end

  // category words carry only their 28-bit mask; the upper part is
  // reserved and forced to zero here rather than left to parameters
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_word <= '0;
    end else if (rd_req && next_src == pmc_pkg::SRC_EVT) begin
      s1_word <= {36'h0, cat_mask[evt_idx]};
    end else if (rd_req && next_src == pmc_pkg::SRC_GCAP) begin
      s1_word <= GCAP_WORD;
    end else begin
      s1_word <= '0;
    end
  end

  // per-counter words come from the table with one cycle of latency,
  // which keeps the wide constant out of the read mux
  pmc_cap_rom #(
    .W        (64),
    .DEPTH    (ROM_DEPTH),
    .AW       (ROM_AW),
    .CONTENTS (CCAP_TAB)
  ) u_ccap_rom (
    .clk     (clk),
    .rst     (rst),
    .rd_en   (rd_req && hit_ccap),
    .rd_idx  (ccap_rel[11:3]),
    .rd_data (rom_data)
  );

  // ----------------------------------------------------------------
  // read pipeline, stage two and write handling
  // ----------------------------------------------------------------
  // writes are accepted and dropped: every register here is constant
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_done <= 1'b0;
    end else begin
      wr_done <= wr_req;
    end
  end

  // answer stage; a source of none yields zero, so idle cycles and
  // unmapped reads look the same on the data lines
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_valid <= 1'b0;
      rd_data  <= '0;
    end else begin
      rd_valid <= s1_valid;
      case (s1_src)
        pmc_pkg::SRC_CCAP: rd_data <= rom_data;
        pmc_pkg::SRC_GCAP,
        pmc_pkg::SRC_EVT:  rd_data <= s1_word;
        default:           rd_data <= '0;
      endcase
    end
  end

endmodule // pmc_capability_regs

`default_nettype wire

// ===== design/pmc_pkg.sv
/*
  pmc_pkg: offsets, field positions and widths for the performance
  monitor capability register bank.
  Assumes byte addresses relative to the monitor table base and
  64-bit aligned read accesses.
*/
package pmc_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int ADDR_W      = 16;
  localparam int DATA_W      = 64;
  localparam int EVT_W       = 28;   // event bitmask width
  localparam int CAT_W       = 4;    // event category number width
  localparam int CNT_IDX_W   = 6;    // counter number width
  localparam int MAX_CATS    = 16;
  localparam int MAX_ENT     = 15;   // entry pairs fitting in 512 bits
  localparam int ENT_W       = 32;   // one category/events pair
  localparam int CCAP_W      = 512;  // per-counter register width
  localparam int CCAP_WORDS  = 8;    // 64-bit words per counter reg

  // ----------------------------------------------------------------
  // register offsets from the table base
  // ----------------------------------------------------------------
  localparam logic [15:0] GCAP_OFS   = 16'h0000;
  localparam logic [15:0] EVT_OFS    = 16'h0080;
  localparam int          EVT_STRIDE = 8;
  localparam logic [15:0] CCAP_OFS   = 16'h0800;
  localparam int          CCAP_STRIDE = 64;

  // ----------------------------------------------------------------
  // global capability fields
  // ----------------------------------------------------------------
  localparam int GCAP_NCNT_LSB = 0;    // 6 bits, number of counters
  localparam int GCAP_CWID_LSB = 8;    // 8 bits, counter width
  localparam int GCAP_NCAT_LSB = 16;   // 4 bits, 19:16
  localparam int GCAP_GCAT_LSB = 20;   // 16 bits, 35:20
  localparam int GCAP_FILT_LSB = 36;   // 8 bits, 43:36
  localparam int GCAP_PCC_BIT  = 52;   // per-counter capability flag

  // ----------------------------------------------------------------
  // category capability and per-counter capability fields
  // ----------------------------------------------------------------
  localparam int EVT_LSB       = 0;    // 27:0, rest reserved
  localparam int CCAP_CWID_LSB = 0;    // 7:0
  localparam int CCAP_NENT_LSB = 28;   // 31:28
  localparam int CCAP_ENT0_LSB = 32;   // entry k at 32 + 32*k
  localparam int ENT_CAT_LSB   = 0;    // category inside an entry
  localparam int ENT_EVT_LSB   = 4;    // events inside an entry

  // read source select
  localparam logic [1:0] SRC_NONE = 2'h0;
  localparam logic [1:0] SRC_GCAP = 2'h1;
  localparam logic [1:0] SRC_EVT  = 2'h2;
  localparam logic [1:0] SRC_CCAP = 2'h3;

endpackage

// ===== design/pmc_cap_rom.sv
/*
  pmc_cap_rom: constant word table with a registered read port.
  Assumes its contents are fixed at elaboration through CONTENTS.
*/
`timescale 1ns/10ps
`default_nettype none

module pmc_cap_rom #(
  parameter int                     W        = 64,
  parameter int                     DEPTH    = 8,
  parameter int                     AW       = 3,
  parameter logic [DEPTH*W-1:0]     CONTENTS = '0
) (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          rd_en,
  input  wire logic [AW-1:0] rd_idx,
  output logic      [W-1:0]  rd_data
);

  // ----------------------------------------------------------------
  // registered read; out-of-range index reads zero
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_data <= '0;
    end else if (rd_en) begin
      if (32'(rd_idx) < DEPTH) begin
        rd_data <= CONTENTS[rd_idx*W +: W];
      end else begin
        rd_data <= '0;
      end
    end
  end

endmodule // pmc_cap_rom

`default_nettype wire

// ===== tb/pmc_capability_regs_props.sv
/*
  pmc_capability_regs_props: port checks for the capability bank.
  Assumes one clock domain, TABLE_BASE 0 and the top module's ports.
*/
`timescale 1ns/10ps
`default_nettype none

module pmc_capability_regs_props (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        rd_req,
  input wire logic        wr_req,
  input wire logic [15:0] addr,
  input wire logic        rd_valid,
  input wire logic [63:0] rd_data,
  input wire logic        wr_done,
  input wire logic        cfg_wr,
  input wire logic [5:0]  cfg_counter,
  input wire logic [3:0]  cfg_category,
  input wire logic [27:0] cfg_events,
  input wire logic        cfg_valid,
  input wire logic [27:0] cfg_events_kept
);
  // ----------------------------------------------------------------
  // checks, muted while reset is high
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_rd_answer_lat: assert property (rd_req |-> ##2 rd_valid)
    else $error("read answer missing");
  a_rd_has_cause: assert property (rd_valid |-> $past(rd_req, 2))
    else $error("read answer without request");
  a_rd_idle_zero: assert property (!rd_valid |-> rd_data == 64'h0)
    else $error("read data not zero while idle");
  a_wr_done_lat: assert property (wr_req |=> wr_done)
    else $error("write not acknowledged");
  a_wr_done_cause: assert property (wr_done |-> $past(wr_req))
    else $error("write acknowledge without request");
  a_cfg_answer_lat: assert property (cfg_wr |=> cfg_valid)
    else $error("filter answer missing");
  a_cfg_idle_zero: assert property (
    !cfg_valid |-> cfg_events_kept == 28'h0)
    else $error("kept events not zero while idle");
  a_cfg_no_extra: assert property (cfg_valid |->
    (cfg_events_kept & ~$past(cfg_events)) == 28'h0)
    else $error("filter kept an unrequested event");
  // reserved part of a category word, address taken two edges back
  a_evt_resv_zero: assert property (rd_valid &&
    $past(addr, 2) inside {[16'h0080:16'h00ff]} |-> rd_data[63:28] == 36'h0)
    else $error("category reserved bits set");
  a_cntr_unused: assert property (rd_valid &&
    $past(addr, 2) >= 16'h0800 && ($past(addr, 2) & 16'h003f) == 16'h0
    |-> rd_data[27:8] == 20'h0)
    else $error("counter unused bits set");
  a_hole_zero: assert property (rd_valid &&
    $past(addr, 2) inside {[16'h0100:16'h07ff]} |-> rd_data == 64'h0)
    else $error("unmapped read not zero");

  c_read_data: cover property (rd_valid && rd_data != 64'h0);
  c_write: cover property (wr_done);
  c_cfg_kept: cover property (cfg_valid && cfg_events_kept != 28'h0);
endmodule // pmc_capability_regs_props

bind pmc_capability_regs pmc_capability_regs_props i_props (
  .clk(clk), .rst(rst), .rd_req(rd_req), .wr_req(wr_req), .addr(addr),
  .rd_valid(rd_valid), .rd_data(rd_data), .wr_done(wr_done),
  .cfg_wr(cfg_wr), .cfg_counter(cfg_counter), .cfg_category(cfg_category),
  .cfg_events(cfg_events), .cfg_valid(cfg_valid),
  .cfg_events_kept(cfg_events_kept));

`default_nettype wire

// ===== tb/pmc_capability_regs_tb_top.sv
/*
  pmc_capability_regs_tb_top: directed checks of the capability bank.
  Assumes TABLE_BASE 0 and the parameter set chosen below.
*/
`timescale 1ns/10ps
`default_nettype none

module pmc_capability_regs_tb_top;
  // category 3 left out globally, counter 1 restricted to two entries
  localparam logic [15:0]    GCATS = 16'h0017;
  localparam logic [447:0]   EMASK = {{11{28'h0}}, 28'h0000f0f,
    28'h0000ff0, 28'h00000ff, 28'h0, 28'hfffffff};
  localparam logic [511:0]   CWID  = {{62{8'h20}}, 8'h28, 8'h20};
  localparam logic [30719:0] ENTS  = (30720'({28'h0000f30, 4'h3}) << 512)
    | (30720'({28'h00000a5, 4'h2}) << 480);
  logic        clk, rst, rd_req, wr_req, rd_valid, wr_done;
  logic        cfg_wr, cfg_valid;
  logic [15:0] addr;
  logic [63:0] rd_data;
  logic [5:0]  cfg_counter;
  logic [3:0]  cfg_category;
  logic [27:0] cfg_events, cfg_events_kept;
  int          fail_count, checks;

  pmc_capability_regs #(.GLOBAL_CATS(GCATS), .EVT_MASKS(EMASK),
    .CNTR_WIDTHS(CWID), .CNTR_NENT(256'h20), .CNTR_ENTRIES(ENTS)) i_dut (
    .clk(clk), .rst(rst), .rd_req(rd_req), .wr_req(wr_req), .addr(addr),
    .rd_valid(rd_valid), .rd_data(rd_data), .wr_done(wr_done),
    .cfg_wr(cfg_wr), .cfg_counter(cfg_counter),
    .cfg_category(cfg_category), .cfg_events(cfg_events),
    .cfg_valid(cfg_valid), .cfg_events_kept(cfg_events_kept));

  // ----------------------------------------------------------------
  // helpers; every driver starts at a falling edge
  // ----------------------------------------------------------------
  task automatic chk(string what, logic [63:0] got, logic [63:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // bounded wait: a stuck answer shows as a mismatch, not a hang
  task automatic rd(input logic [15:0] a, output logic [63:0] d);
    rd_req = 1'b1;
    addr = a;
    @(negedge clk);
    rd_req = 1'b0;
    for (int i = 0; i < 3 && rd_valid !== 1'b1; i++) @(negedge clk);
    chk("rd_valid", {63'h0, rd_valid}, 64'h1);
    d = rd_data;
  endtask

  task automatic cfg(logic [5:0] n, logic [3:0] c, logic [27:0] exp);
    cfg_wr = 1'b1;
    cfg_counter = n;
    cfg_category = c;
    cfg_events = 28'hfffffff;
    @(negedge clk);
    chk("cfg_valid", {63'h0, cfg_valid}, 64'h1);
    chk("kept", {36'h0, cfg_events_kept}, {36'h0, exp});
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    logic [63:0]  d;
    logic [511:0] e;
    rd(16'h0000, d);
    chk("global", d, (64'h1 << 52) | (64'(GCATS) << 20) |
      (64'h5 << 16) | (64'h30 << 8) | 64'h4);
    for (int c = 0; c < 7; c++) begin
      rd(16'h0080 + 16'(8 * c), d);
      e[63:0] = (c < 5) ? {36'h0, EMASK[28*c +: 28]} : 64'h0;
      chk("category", d, e[63:0]);
    end
    rd(16'h0084, d);
    chk("misaligned", d, 64'h0);
    rd(16'h0400, d);
    chk("hole", d, 64'h0);
    for (int n = 0; n < 5; n++) begin
      e = (n < 4) ? {480'h0, 24'h0, CWID[8*n +: 8]} : 512'h0;
      if (n == 1) e[95:28] = {28'h0000f30, 4'h3, 28'h00000a5, 4'h2, 4'h2};
      for (int w = 0; w < 8; w++) begin
        rd(16'h0800 + 16'(64 * n + 8 * w), d);
        chk("counter", d, e[64*w +: 64]);
      end
    end
    $display("test registers done");
  endtask

  task automatic t_writes();
    logic [63:0] d;
    wr_req = 1'b1;
    addr = 16'h0080;
    @(negedge clk);
    chk("wr_done", {63'h0, wr_done}, 64'h1);
    @(negedge clk);
    wr_req = 1'b0;
    chk("wr_done", {63'h0, wr_done}, 64'h1);
    rd(16'h0080, d);
    chk("after write", d, 64'h000000000fffffff);
    $display("test writes done");
  endtask

  task automatic t_filter();
    cfg(6'h0, 4'h0, 28'hfffffff);
    cfg(6'h0, 4'h2, 28'h00000ff);
    cfg(6'h0, 4'h1, 28'h0000000);
    cfg(6'h0, 4'h3, 28'h0000000);
    cfg(6'h1, 4'h3, 28'h0000f30);
    cfg(6'h1, 4'h2, 28'h00000a5);
    cfg(6'h1, 4'h0, 28'h0000000);
    cfg(6'h5, 4'h0, 28'h0000000);
    cfg_wr = 1'b0;
    $display("test filter done");
  endtask

  // ----------------------------------------------------------------
  // clock, watchdog and main sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial begin
    #200000;
    fail_count++;
    finish_test();
  end

  initial begin
    {rst, rd_req, wr_req, cfg_wr} = 4'hf << 3;
    {addr, cfg_counter, cfg_category, cfg_events} = '0;
    repeat (3) @(posedge clk);
    @(negedge clk) rst = 1'b0;
    t_regs();
    t_writes();
    t_filter();
    finish_test();
  end
endmodule // pmc_capability_regs_tb_top

`default_nettype wire
